// ### src/dcm_top.sv
// Converter core switching mode and clock input trim registers
// How it works
// - Two-bit mode: 00 non-return-to-zero, 10 return-to-zero, 01 chopped mixing.
// - Return-to-zero: data on rising edge, zero on the following falling edge.
// - Chopped: falling edge value is complement of the preceding rising sample.
// - Non-return-to-zero: same sample on rising and falling edge.
// - One switch pair per half period, pairs clocked on opposite edges.
// - Clock control registers sit at addresses 0x082 through 0x084.
// - Duty trim bit 7 enables duty cycle correction.
// - Duty trim bit 6 enables offset; bits 4:0 hold the offset.
// - Duty offset is sign-magnitude: bit 4 negative sign, bits 3:0 magnitude.
// - Phase trim is a six-bit sign-magnitude field at 0x07F.
// - Positive codes add 20 fF steps to plus input, negative to minus.
`timescale 1ns/1ns
module dcm_top #(
  parameter int                DATA_W    = 16,
  parameter logic [DATA_W-1:0] ZERO_CODE = {1'b1, {(DATA_W-1){1'b0}}}
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              SPI_CS_N,
  input  wire logic              SPI_SCLK,
  input  wire logic              SPI_SDI,
  output logic                   SPI_SDO,
  output logic                   SPI_SDO_OE_N,
  input  wire logic [DATA_W-1:0] SAMPLE_IN,
  output logic [DATA_W-1:0]      PAIR_RISE_DATA,
  output logic [DATA_W-1:0]      PAIR_FALL_DATA,
  output logic [1:0]             ACTIVE_MODE,
  output logic                   DUTY_CORR_EN,
  output logic                   DUTY_OFS_EN,
  output logic                   DUTY_OFS_NEG,
  output logic [3:0]             DUTY_OFS_MAG,
  output logic [4:0]             PHASE_CAP_POS,
  output logic [4:0]             PHASE_CAP_NEG
);
  if (DATA_W < 2 || DATA_W > 16) begin : g_chk
    $error("DATA_W must lie between 2 and 16");
  end

  logic [7:0] phase_trim;
  logic [7:0] duty_trim;
  logic [7:0] clk_ctrl_aux [2];
  logic [7:0] switch_mode;

  logic [14:0] spi_addr;
  logic [7:0]  spi_wr_data;
  logic        spi_wr_stb;
  logic [7:0]  rd_data;

  logic       dec_corr_en;
  logic       dec_ofs_en;
  logic       dec_ofs_neg;
  logic [3:0] dec_ofs_mag;
  logic [4:0] dec_cap_pos;
  logic [4:0] dec_cap_neg;

  dcm_spi_slave u_spi (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .cs_n     (SPI_CS_N),
    .sclk     (SPI_SCLK),
    .sdi      (SPI_SDI),
    .rd_data  (rd_data),
    .addr     (spi_addr),
    .wr_data  (spi_wr_data),
    .wr_stb   (spi_wr_stb),
    .sdo      (SPI_SDO),
    .sdo_oe_n (SPI_SDO_OE_N)
  );

  // Address decode
  wire sel_phase = spi_addr == dcm_pkg::ADDR_PHASE_TRIM;
  wire sel_duty  = spi_addr == dcm_pkg::ADDR_DUTY_TRIM;
  wire sel_aux1  = spi_addr == dcm_pkg::ADDR_CLK_CTRL_LO + 15'h0001;
  wire sel_aux2  = spi_addr == dcm_pkg::ADDR_CLK_CTRL_HI;
  wire sel_mode  = spi_addr == dcm_pkg::ADDR_SWITCH_MODE;

  // Unmapped addresses read as zero
  assign rd_data = sel_phase ? phase_trim :
                   sel_duty  ? duty_trim :
                   sel_aux1  ? clk_ctrl_aux[0] :
                   sel_aux2  ? clk_ctrl_aux[1] :
                   sel_mode  ? {6'h00, ACTIVE_MODE} : 8'h00;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase_trim      <= dcm_pkg::RST_PHASE_TRIM;
      duty_trim       <= dcm_pkg::RST_DUTY_TRIM;
      clk_ctrl_aux[0] <= dcm_pkg::RST_CLK_AUX;
      clk_ctrl_aux[1] <= dcm_pkg::RST_CLK_AUX;
      switch_mode     <= dcm_pkg::RST_MODE;
    end else if (spi_wr_stb) begin
      if (sel_phase) phase_trim <= {2'b00, spi_wr_data[5:0]};
      if (sel_duty)  duty_trim <= {spi_wr_data[7:6], 1'b0, spi_wr_data[4:0]};
      if (sel_aux1)  clk_ctrl_aux[0] <= spi_wr_data;
      if (sel_aux2)  clk_ctrl_aux[1] <= spi_wr_data;
      if (sel_mode)  switch_mode <= {6'h00, spi_wr_data[1:0]};
    end
  end

  dcm_trim_decode u_dec (
    .duty_reg      (duty_trim),
    .phase_reg     (phase_trim),
    .duty_corr_en  (dec_corr_en),
    .duty_ofs_en   (dec_ofs_en),
    .duty_ofs_neg  (dec_ofs_neg),
    .duty_ofs_mag  (dec_ofs_mag),
    .phase_cap_pos (dec_cap_pos),
    .phase_cap_neg (dec_cap_neg)
  );

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DUTY_CORR_EN  <= 1'b0;
      DUTY_OFS_EN   <= 1'b0;
      DUTY_OFS_NEG  <= 1'b0;
      DUTY_OFS_MAG  <= 4'h0;
      PHASE_CAP_POS <= 5'h00;
      PHASE_CAP_NEG <= 5'h00;
    end else begin
      DUTY_CORR_EN  <= dec_corr_en;
      DUTY_OFS_EN   <= dec_ofs_en;
      DUTY_OFS_NEG  <= dec_ofs_neg;
      DUTY_OFS_MAG  <= dec_ofs_mag;
      PHASE_CAP_POS <= dec_cap_pos;
      PHASE_CAP_NEG <= dec_cap_neg;
    end
  end

  // One core clock is one converter period. The mode and both half
  // samples load on the same edge, so no period mixes two modes.
  dcm_pkg::dcm_mode_type next_mode;
  assign next_mode = dcm_pkg::dcm_mode_type'(switch_mode[1:0]);

  logic [DATA_W-1:0] next_fall;
  always_comb begin
    unique case (next_mode)
      dcm_pkg::DCM_RZ:  next_fall = ZERO_CODE;
      dcm_pkg::DCM_MIX: next_fall = ~SAMPLE_IN;
      // Reserved code behaves as non-return-to-zero
      dcm_pkg::DCM_NRZ,
      dcm_pkg::DCM_RSVD: next_fall = SAMPLE_IN;
    endcase
  end

  // Rise pair is switched on the rising edge, fall pair on the falling
  // edge; each output feeds only its own pair.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE_MODE    <= dcm_pkg::RST_MODE[1:0];
      PAIR_RISE_DATA <= ZERO_CODE;
      PAIR_FALL_DATA <= ZERO_CODE;
    end else begin
      ACTIVE_MODE    <= next_mode;
      PAIR_RISE_DATA <= SAMPLE_IN;
      PAIR_FALL_DATA <= next_fall;
    end
  end

  property p_rz_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    next_mode == dcm_pkg::DCM_RZ |=> PAIR_FALL_DATA == ZERO_CODE;
  endproperty
  a_rz_zero: assert property (p_rz_zero) else $error("fall half not zero in RZ");

  property p_mix_compl;
    @(posedge CLOCK) disable iff (!RST_N)
    ACTIVE_MODE == dcm_pkg::DCM_MIX |-> PAIR_FALL_DATA == ~PAIR_RISE_DATA;
  endproperty
  a_mix_compl: assert property (p_mix_compl) else $error("fall half not complement");

  property p_nrz_same;
    @(posedge CLOCK) disable iff (!RST_N)
    ACTIVE_MODE == dcm_pkg::DCM_NRZ |-> PAIR_FALL_DATA == PAIR_RISE_DATA;
  endproperty
  a_nrz_same: assert property (p_nrz_same) else $error("NRZ halves differ");

  property p_rise_data;
    @(posedge CLOCK) disable iff (!RST_N)
    1'b1 |=> PAIR_RISE_DATA == $past(SAMPLE_IN);
  endproperty
  a_rise_data: assert property (p_rise_data) else $error("rise half lost sample");

  property p_mode_write;
    @(posedge CLOCK) disable iff (!RST_N)
    spi_wr_stb && sel_mode |-> ##2 ACTIVE_MODE == $past(spi_wr_data[1:0], 2);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not applied");

  property p_mode_stable;
    @(posedge CLOCK) disable iff (!RST_N)
    !(spi_wr_stb && sel_mode) ##1 1'b1 |=> $stable(ACTIVE_MODE);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed without write");

  property p_duty_corr;
    @(posedge CLOCK) disable iff (!RST_N)
    spi_wr_stb && sel_duty |-> ##2 DUTY_CORR_EN == $past(spi_wr_data[7], 2);
  endproperty
  a_duty_corr: assert property (p_duty_corr) else $error("correction enable wrong");

  property p_ofs_gate;
    @(posedge CLOCK) disable iff (!RST_N)
    !DUTY_OFS_EN |-> DUTY_OFS_MAG == 4'h0 && !DUTY_OFS_NEG;
  endproperty
  a_ofs_gate: assert property (p_ofs_gate) else $error("offset active while off");

  property p_ofs_sign;
    @(posedge CLOCK) disable iff (!RST_N)
    spi_wr_stb && sel_duty && spi_wr_data[6] |-> ##2
      DUTY_OFS_NEG == $past(spi_wr_data[4], 2) && DUTY_OFS_MAG == $past(spi_wr_data[3:0], 2);
  endproperty
  a_ofs_sign: assert property (p_ofs_sign) else $error("offset decode wrong");

  property p_phase_side;
    @(posedge CLOCK) disable iff (!RST_N)
    PHASE_CAP_POS == 5'h00 || PHASE_CAP_NEG == 5'h00;
  endproperty
  a_phase_side: assert property (p_phase_side) else $error("capacitance on both inputs");

  property p_phase_code;
    @(posedge CLOCK) disable iff (!RST_N)
    spi_wr_stb && sel_phase |-> ##2
      {PHASE_CAP_NEG, PHASE_CAP_POS} == ($past(spi_wr_data[5], 2)
        ? {$past(spi_wr_data[4:0], 2), 5'h00} : {5'h00, $past(spi_wr_data[4:0], 2)});
  endproperty
  a_phase_code: assert property (p_phase_code) else $error("phase trim decode wrong");

  property p_rsvd_same;
    @(posedge CLOCK) disable iff (!RST_N)
    ACTIVE_MODE == dcm_pkg::DCM_RSVD |-> PAIR_FALL_DATA == PAIR_RISE_DATA;
  endproperty
  a_rsvd_same: assert property (p_rsvd_same) else $error("reserved mode halves differ");

  property p_rz_active;
    @(posedge CLOCK) disable iff (!RST_N)
    ACTIVE_MODE == dcm_pkg::DCM_RZ |-> PAIR_FALL_DATA == ZERO_CODE;
  endproperty
  a_rz_active: assert property (p_rz_active) else $error("RZ period mixed with other mode");

  property p_ofs_en_write;
    @(posedge CLOCK) disable iff (!RST_N)
    spi_wr_stb && sel_duty |-> ##2 DUTY_OFS_EN == $past(spi_wr_data[6], 2);
  endproperty
  a_ofs_en_write: assert property (p_ofs_en_write) else $error("offset enable wrong");

  property p_sdo_idle;
    @(posedge CLOCK) disable iff (!RST_N)
    SPI_CS_N |=> SPI_SDO_OE_N;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("read data driven while deselected");
endmodule

// ### src/dcm_pkg.sv
// Shared constants for the converter core mode and clock trim block
package dcm_pkg;
  // Configuration map addresses
  localparam int          ADDR_W           = 15;
  localparam logic [14:0] ADDR_PHASE_TRIM  = 15'h007F;
  localparam logic [14:0] ADDR_DUTY_TRIM   = 15'h0082;
  localparam logic [14:0] ADDR_CLK_CTRL_LO = 15'h0082;
  localparam logic [14:0] ADDR_CLK_CTRL_HI = 15'h0084;
  localparam logic [14:0] ADDR_SWITCH_MODE = 15'h0152;

  // Reset values of every register
  localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
  localparam logic [7:0] RST_DUTY_TRIM  = 8'h00;
  localparam logic [7:0] RST_CLK_AUX    = 8'h00;
  localparam logic [7:0] RST_MODE       = 8'h00;

  // Duty trim field positions
  localparam int DUTY_CORR_BIT  = 7;
  localparam int DUTY_OFS_BIT   = 6;
  localparam int DUTY_SIGN_BIT  = 4;
  localparam int DUTY_MAG_W     = 4;

  // Phase trim field positions
  localparam int PHASE_SIGN_BIT = 5;
  localparam int PHASE_MAG_W    = 5;

  // Serial frame layout: read flag, address, one data byte
  localparam int          FRAME_HDR   = 16;
  localparam int          FRAME_LEN   = 24;
  localparam logic [4:0]  CNT_HDR     = 5'h10;
  localparam logic [4:0]  CNT_END     = 5'h18;

  typedef enum logic [1:0] {
    DCM_NRZ  = 2'b00,
    DCM_MIX  = 2'b01,
    DCM_RZ   = 2'b10,
    DCM_RSVD = 2'b11
  } dcm_mode_type;
endpackage

// ### src/dcm_trim_decode.sv
// Sign and magnitude decode of the clock trim codes
`timescale 1ns/1ns
module dcm_trim_decode (
  input  wire logic [7:0] duty_reg,
  input  wire logic [7:0] phase_reg,
  output logic            duty_corr_en,
  output logic            duty_ofs_en,
  output logic            duty_ofs_neg,
  output logic [3:0]      duty_ofs_mag,
  output logic [4:0]      phase_cap_pos,
  output logic [4:0]      phase_cap_neg
);
  wire       phase_neg = phase_reg[dcm_pkg::PHASE_SIGN_BIT];
  wire [4:0] phase_mag = phase_reg[dcm_pkg::PHASE_MAG_W-1:0];
  wire       ofs_en    = duty_reg[dcm_pkg::DUTY_OFS_BIT];

  assign duty_corr_en  = duty_reg[dcm_pkg::DUTY_CORR_BIT];
  assign duty_ofs_en   = ofs_en;
  // Offset only reaches the receiver while offset control is on
  assign duty_ofs_neg  = ofs_en & duty_reg[dcm_pkg::DUTY_SIGN_BIT];
  assign duty_ofs_mag  = ofs_en ? duty_reg[dcm_pkg::DUTY_MAG_W-1:0] : 4'h0;
  // Both zero codes add nothing on either side
  assign phase_cap_pos = phase_neg ? 5'h00 : phase_mag;
  assign phase_cap_neg = phase_neg ? phase_mag : 5'h00;
endmodule

// ### src/dcm_spi_slave.sv
// Serial management port slave, sampled on the core clock
`timescale 1ns/1ns
module dcm_spi_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic [7:0]  rd_data,
  output logic [14:0]      addr,
  output logic [7:0]       wr_data,
  output logic             wr_stb,
  output logic             sdo,
  output logic             sdo_oe_n
);
  logic        sclk_q;
  logic [4:0]  bit_cnt;
  logic [23:0] shreg;
  logic [7:0]  out_sr;
  logic        rd_frame;

  wire sclk_rise = sclk & ~sclk_q & ~cs_n;
  wire sclk_fall = ~sclk & sclk_q & ~cs_n;
  wire hdr_done  = sclk_rise & (bit_cnt == dcm_pkg::CNT_HDR - 5'h01);
  wire frm_done  = sclk_rise & (bit_cnt == dcm_pkg::CNT_END - 5'h01);
  wire [23:0] next_shreg = {shreg[22:0], sdi};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q   <= 1'b0;
      bit_cnt  <= 5'h00;
      shreg    <= 24'h000000;
      rd_frame <= 1'b0;
      addr     <= 15'h0000;
      wr_data  <= 8'h00;
      wr_stb   <= 1'b0;
    end else begin
      sclk_q <= sclk;
      wr_stb <= 1'b0;
      if (cs_n) begin
        bit_cnt  <= 5'h00;
        rd_frame <= 1'b0;
      end else if (sclk_rise && bit_cnt != dcm_pkg::CNT_END) begin
        bit_cnt <= bit_cnt + 5'h01;
        shreg   <= next_shreg;
        if (hdr_done) begin
          rd_frame <= next_shreg[15];
          addr     <= next_shreg[14:0];
        end
        // Short frames are dropped: no write without all 24 bits
        if (frm_done && !rd_frame) begin
          wr_data <= next_shreg[7:0];
          wr_stb  <= 1'b1;
        end
      end
    end
  end

  // Read data leaves MSB first on falling edges, master samples on rising
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sr   <= 8'h00;
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (cs_n || !rd_frame || bit_cnt == dcm_pkg::CNT_END) begin
      sdo_oe_n <= 1'b1;
      out_sr   <= rd_data;
    end else if (sclk_fall) begin
      // First fall of a read takes the byte of the address just received,
      // since out_sr was last loaded while the previous address still stood
      sdo      <= sdo_oe_n ? rd_data[7] : out_sr[7];
      out_sr   <= sdo_oe_n ? {rd_data[6:0], 1'b0} : {out_sr[6:0], 1'b0};
      sdo_oe_n <= 1'b0;
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the core switching mode and clock trim block
`timescale 1ns/1ns
module testbench;
  localparam int         DW   = 16;
  localparam logic [15:0] ZERO = 16'h8000;
  logic          clock;
  logic          rst_n;
  logic          cs_n;
  logic          sclk;
  logic          sdi;
  logic          sdo;
  logic          sdo_oe_n;
  logic [DW-1:0] sample;
  logic [DW-1:0] rise;
  logic [DW-1:0] fall;
  logic [1:0]    mode_o;
  logic          corr;
  logic          ofs_en;
  logic          ofs_neg;
  logic [3:0]    ofs_mag;
  logic [4:0]    cap_pos;
  logic [4:0]    cap_neg;
  logic [7:0]    m_phase;
  logic [7:0]    m_duty;
  logic [7:0]    m_aux3;
  logic [7:0]    m_aux4;
  logic [7:0]    m_mode;
  logic [7:0]    q;
  int            miscompares;
  int            compares;

  dcm_top u_dcm_top (
    .CLOCK          (clock),
    .RST_N          (rst_n),
    .SPI_CS_N       (cs_n),
    .SPI_SCLK       (sclk),
    .SPI_SDI        (sdi),
    .SPI_SDO        (sdo),
    .SPI_SDO_OE_N   (sdo_oe_n),
    .SAMPLE_IN      (sample),
    .PAIR_RISE_DATA (rise),
    .PAIR_FALL_DATA (fall),
    .ACTIVE_MODE    (mode_o),
    .DUTY_CORR_EN   (corr),
    .DUTY_OFS_EN    (ofs_en),
    .DUTY_OFS_NEG   (ofs_neg),
    .DUTY_OFS_MAG   (ofs_mag),
    .PHASE_CAP_POS  (cap_pos),
    .PHASE_CAP_NEG  (cap_neg)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // SCLK kept three core cycles per phase, above the one the sampler needs
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] d, input int nbits);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    cs_n = 1'b0;
    cyc(1);
    for (int i = 0; i < nbits; i++) begin
      sdi  = f[23-i];
      sclk = 1'b0;
      cyc(3);
      if (rd && i >= 16) begin
        q[23-i] = sdo;
        check(sdo_oe_n, 1'b0);
      end
      sclk = 1'b1;
      cyc(3);
    end
    sclk = 1'b0;
    sdi  = ~sdi;
    cyc(1);
    cs_n = 1'b1;
    cyc(5);
  endtask

  function automatic logic [7:0] model_rd(input logic [14:0] a);
    case (a)
      15'h007F: return m_phase;
      15'h0082: return m_duty;
      15'h0083: return m_aux3;
      15'h0084: return m_aux4;
      15'h0152: return m_mode;
      default:  return 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d, 24);
    case (a)
      15'h007F: m_phase = d & 8'h3F;
      15'h0082: m_duty  = d & 8'hDF;
      15'h0083: m_aux3  = d;
      15'h0084: m_aux4  = d;
      15'h0152: m_mode  = d & 8'h03;
      default:  ;
    endcase
  endtask

  task automatic rd_chk(input logic [14:0] a);
    spi(1'b1, a, 8'h00, 24);
    check(q, model_rd(a));
  endtask

  task automatic trim_chk;
    check(corr, m_duty[7]);
    check(ofs_en, m_duty[6]);
    check(ofs_neg, m_duty[6] & m_duty[4]);
    check(ofs_mag, m_duty[6] ? m_duty[3:0] : 4'h0);
    check(cap_pos, m_phase[5] ? 5'h00 : m_phase[4:0]);
    check(cap_neg, m_phase[5] ? m_phase[4:0] : 5'h00);
    check(mode_o, m_mode[1:0]);
  endtask

  task automatic all_rd;
    rd_chk(15'h007F);
    rd_chk(15'h0082);
    rd_chk(15'h0083);
    rd_chk(15'h0084);
    rd_chk(15'h0152);
  endtask

  task automatic run_samples(input int n);
    logic [15:0] prev;
    logic [15:0] exp_fall;
    for (int i = 0; i < n; i++) begin
      prev   = 16'($urandom);
      sample = prev;
      cyc(1);
      case (m_mode[1:0])
        2'b10:   exp_fall = ZERO;
        2'b01:   exp_fall = ~prev;
        default: exp_fall = prev;
      endcase
      check(rise, prev);
      check(fall, exp_fall);
      check(mode_o, m_mode[1:0]);
    end
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    cyc(5);
    check(rise, ZERO);
    check(fall, ZERO);
    check(sdo_oe_n, 1'b1);
    {m_phase, m_duty, m_aux3, m_aux4, m_mode} = '0;
    trim_chk();
    rst_n = 1'b1;
    cyc(1);
  endtask

  // Boundary phase and duty codes first, random ones after
  logic [7:0] edge_codes [6] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'h3F};

  initial begin
    {cs_n, sclk, sdi, sample, rst_n} = {3'b100, 16'h0000, 1'b0};
    miscompares = 0;
    compares = 0;
    void'($urandom(27245));
    do_reset();
    all_rd();
    for (int m = 0; m < 4; m++) begin
      wr(15'h0152, 8'(m));
      trim_chk();
      rd_chk(15'h0152);
      run_samples(24);
    end
    for (int i = 0; i < 14; i++) begin
      wr(15'h007F, i < 6 ? edge_codes[i] : 8'($urandom));
      wr(15'h0082, i < 6 ? (edge_codes[i] | 8'hC0) : 8'($urandom));
      trim_chk();
      rd_chk(15'h007F);
      rd_chk(15'h0082);
    end
    wr(15'h0083, 8'($urandom));
    wr(15'h0084, 8'($urandom));
    wr(15'h0100, 8'hA5);
    rd_chk(15'h0100);
    // A frame cut short must leave the mode register alone
    spi(1'b0, 15'h0152, 8'h02, 12);
    spi(1'b0, 15'h0152, 8'h02, 23);
    all_rd();
    trim_chk();
    run_samples(8);
    wr(15'h0152, 8'h02);
    do_reset();
    all_rd();
    run_samples(8);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    $display("[ERR] %0t run did not complete in time", $time);
    tally_and_finish();
  end
endmodule
